// [logic/vsc_pkg.sv]
package vsc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [7:0] ADDR_FAST    = 8'h00;
    localparam logic [7:0] ADDR_SIDE    = 8'h01;
    localparam logic [7:0] ADDR_RXTERM  = 8'h10;
    localparam logic [7:0] ADDR_PULS_AB = 8'h11;
    localparam logic [7:0] ADDR_PULS_CD = 8'h12;
    localparam logic [7:0] ADDR_EQ_AB   = 8'h13;
    localparam logic [7:0] ADDR_EQ_CD   = 8'h14;
    localparam logic [7:0] ADDR_TX      = 8'h20;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] RST_FAST   = 8'h40;
    localparam logic [7:0] RST_SIDE   = 8'h40;
    localparam logic [7:0] RST_RXTERM = 8'h01;
    localparam logic [7:0] RST_PULS   = 8'h00;
    localparam logic [7:0] RST_EQ     = 8'h00;
    localparam logic [7:0] RST_TX     = 8'h03;

    ////////////////////////////////////////////////////////////////////////////
    // field layout
    localparam int         BIT_EN     = 6;
    localparam int         BIT_RXTERM = 0;
    localparam int         SEL_W      = 2;
    localparam int         TX_W       = 4;
    localparam int         CH_W       = 16;
    localparam logic [7:0] READ_NONE  = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // serial link
    localparam logic [3:0] SLAVE_ID_HI = 4'h9;
    localparam logic [3:0] BYTE_BITS   = 4'h8;
    localparam logic [3:0] BIT_ZERO    = 4'h0;
    localparam int         SYNC_W      = 5;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_HZ            = 10000000;
    localparam int TERM_PULSE_MS     = 100;
    localparam int TERM_PULSE_CYCLES = TERM_PULSE_MS * (CLK_HZ / 1000);
    localparam int PULSE_CNT_W       = 20;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_DEV  = 5'h02,
        ST_REG  = 5'h04,
        ST_WR   = 5'h08,
        ST_RD   = 5'h10
    } vsc_state_type;

endpackage

// [logic/vsc_config_regs.sv]
`timescale 1ns/100ps
// Function
// - all registers readable and writable over serial
// - address low bits from three strap pins
// - first serial access disables parallel path
// - fast path register 0x00, default 0x40
// - side path register 0x01, default 0x40
// - termination pulse masks at 0x11, 0x12
// - transmitter settings 0x20, default 0x03
// - fast enable low means channels off, standby
// - fast select picks input group A..D
// - side select picks auxiliary group A..D
// - input termination bit switches termination
// - masked channels lose termination 100 ms
// - equalizer bit low 6 dB, high 12 dB
module vsc_config_regs #(
    parameter int TERM_PULSE_CYCLES = vsc_pkg::TERM_PULSE_CYCLES
) (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // serial link and straps
    input  wire logic        i_scl,
    input  wire logic        i_sda,
    output logic             o_sda,
    output logic             o_sda_oe,
    input  wire logic        i_slave_id_pin_2,
    input  wire logic        i_slave_id_pin_1,
    input  wire logic        i_slave_id_pin_0,
    // switch controls
    output logic             o_fast_path_enable,
    output logic             o_standby,
    output logic [1:0]       o_fast_source_select,
    output logic             o_side_path_enable,
    output logic [1:0]       o_side_source_select,
    output logic [15:0]      o_input_termination_on,
    output logic [15:0]      o_equalizer_level_bits,
    output logic [1:0]       o_output_preemphasis_level,
    output logic             o_output_termination_on,
    output logic             o_output_current_level,
    output logic             o_parallel_path_off
);
    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: three stages, accept once stages two and three agree
    logic [4:0]                  sync1_q;
    logic [4:0]                  sync2_q;
    logic [4:0]                  sync3_q;
    logic [4:0]                  filt_q;
    logic [4:0]                  agree;
    logic                        scl_rise;
    logic                        scl_fall;
    logic                        start_det;
    logic                        stop_det;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sync1_q <= 5'h1f;
            sync2_q <= 5'h1f;
            sync3_q <= 5'h1f;
        end else begin
            sync1_q <= {i_scl, i_sda, i_slave_id_pin_2, i_slave_id_pin_1, i_slave_id_pin_0};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end
    assign agree = ~(sync2_q ^ sync3_q);
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            filt_q <= 5'h1f;
        end else begin
            filt_q <= (sync3_q & agree) | (filt_q & ~agree);
        end
    end
    // bit 4 is the clock line, bit 3 the data line
    assign scl_rise  = agree[4] & sync3_q[4] & ~filt_q[4];
    assign scl_fall  = agree[4] & ~sync3_q[4] & filt_q[4];
    assign start_det = filt_q[4] & agree[4] & sync3_q[4] & agree[3] & ~sync3_q[3] & filt_q[3];
    assign stop_det  = filt_q[4] & agree[4] & sync3_q[4] & agree[3] & sync3_q[3] & ~filt_q[3];

    ////////////////////////////////////////////////////////////////////////////
    // configuration state
    logic                        fast_en_q;
    logic [1:0]                  fast_sel_q;
    logic                        side_en_q;
    logic [1:0]                  side_sel_q;
    logic                        rx_term_q;
    logic [15:0]                 pulse_mask_q;
    logic [15:0]                 eq_bits_q;
    logic [3:0]                  tx_set_q;
    // unused bits read as zero
    function automatic logic [7:0] reg_read(input logic [7:0] addr);
        logic [7:0] v;
        v = vsc_pkg::READ_NONE;
        case (addr)
            vsc_pkg::ADDR_FAST: begin
                v[vsc_pkg::BIT_EN]        = fast_en_q;
                v[vsc_pkg::SEL_W-1:0]     = fast_sel_q;
            end
            vsc_pkg::ADDR_SIDE: begin
                v[vsc_pkg::BIT_EN]        = side_en_q;
                v[vsc_pkg::SEL_W-1:0]     = side_sel_q;
            end
            vsc_pkg::ADDR_RXTERM:  v[vsc_pkg::BIT_RXTERM] = rx_term_q;
            vsc_pkg::ADDR_PULS_AB: v = pulse_mask_q[7:0];
            vsc_pkg::ADDR_PULS_CD: v = pulse_mask_q[15:8];
            vsc_pkg::ADDR_EQ_AB:   v = eq_bits_q[7:0];
            vsc_pkg::ADDR_EQ_CD:   v = eq_bits_q[15:8];
            vsc_pkg::ADDR_TX:      v[vsc_pkg::TX_W-1:0] = tx_set_q;
            default:               v = vsc_pkg::READ_NONE;
        endcase
        return v;
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    // serial slave
    vsc_pkg::vsc_state_type      state_q;
    logic [3:0]                  bitcnt_q;
    logic [7:0]                  rx_shift_q;
    logic [7:0]                  tx_shift_q;
    logic [7:0]                  ptr_q;
    logic                        ack_q;
    logic                        rw_q;
    logic                        nack_q;
    logic                        sda_oe_q;
    logic                        byte_done;
    logic                        dev_match;
    logic                        wr_en;
    logic [7:0]                  rd_data;
    assign byte_done = scl_fall & ~ack_q & (bitcnt_q == vsc_pkg::BYTE_BITS);
    assign dev_match = rx_shift_q[7:1] == {vsc_pkg::SLAVE_ID_HI, filt_q[2:0]};
    assign wr_en     = byte_done & (state_q == vsc_pkg::ST_WR);
    // always_comb, so a write to the pointed register is seen without a pointer change
    always_comb rd_data = reg_read(ptr_q);
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_q    <= vsc_pkg::ST_IDLE;
            bitcnt_q   <= vsc_pkg::BIT_ZERO;
            rx_shift_q <= 8'h00;
            tx_shift_q <= 8'h00;
            ptr_q      <= 8'h00;
            ack_q      <= 1'b0;
            rw_q       <= 1'b0;
            nack_q     <= 1'b0;
            sda_oe_q   <= 1'b0;
        end else if (start_det) begin
            // repeated start lands here too
            state_q  <= vsc_pkg::ST_DEV;
            bitcnt_q <= vsc_pkg::BIT_ZERO;
            ack_q    <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (stop_det) begin
            state_q  <= vsc_pkg::ST_IDLE;
            ack_q    <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (scl_rise && state_q != vsc_pkg::ST_IDLE) begin
            if (bitcnt_q != vsc_pkg::BYTE_BITS) begin
                rx_shift_q <= {rx_shift_q[6:0], filt_q[3]};
                bitcnt_q   <= 4'(bitcnt_q + 4'h1);
            end else begin
                nack_q <= sync3_q[3];
            end
        end else if (byte_done) begin
            ack_q <= 1'b1;
            case (state_q)
                vsc_pkg::ST_DEV: begin
                    if (dev_match) begin
                        sda_oe_q <= 1'b1;
                        rw_q     <= rx_shift_q[0];
                    end else begin
                        state_q <= vsc_pkg::ST_IDLE;
                    end
                end
                vsc_pkg::ST_REG: begin
                    ptr_q    <= rx_shift_q;
                    sda_oe_q <= 1'b1;
                end
                vsc_pkg::ST_WR:  sda_oe_q <= 1'b1;
                vsc_pkg::ST_RD:  sda_oe_q <= 1'b0;
                default:         state_q  <= vsc_pkg::ST_IDLE;
            endcase
        end else if (scl_fall && ack_q) begin
            ack_q    <= 1'b0;
            bitcnt_q <= vsc_pkg::BIT_ZERO;
            sda_oe_q <= 1'b0;
            case (state_q)
                vsc_pkg::ST_DEV: begin
                    if (rw_q) begin
                        state_q    <= vsc_pkg::ST_RD;
                        tx_shift_q <= rd_data;
                        sda_oe_q   <= ~rd_data[7];
                    end else begin
                        state_q <= vsc_pkg::ST_REG;
                    end
                end
                vsc_pkg::ST_REG: state_q <= vsc_pkg::ST_WR;
                vsc_pkg::ST_WR:  state_q <= vsc_pkg::ST_WR;
                vsc_pkg::ST_RD: begin
                    // master nack ends the read; ack rereads the same register
                    if (nack_q) begin
                        state_q <= vsc_pkg::ST_IDLE;
                    end else begin
                        tx_shift_q <= rd_data;
                        sda_oe_q   <= ~rd_data[7];
                    end
                end
                default:         state_q <= vsc_pkg::ST_IDLE;
            endcase
        end else if (scl_fall && state_q == vsc_pkg::ST_RD) begin
            tx_shift_q <= {tx_shift_q[6:0], 1'b0};
            sda_oe_q   <= ~tx_shift_q[6];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // serial access flag, sticky until reset
    logic                        serial_used_q;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            serial_used_q <= 1'b0;
        end else if (byte_done && state_q == vsc_pkg::ST_DEV && dev_match) begin
            serial_used_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register writes; unmapped offsets are ignored
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            fast_en_q    <= vsc_pkg::RST_FAST[vsc_pkg::BIT_EN];
            fast_sel_q   <= vsc_pkg::RST_FAST[vsc_pkg::SEL_W-1:0];
            side_en_q    <= vsc_pkg::RST_SIDE[vsc_pkg::BIT_EN];
            side_sel_q   <= vsc_pkg::RST_SIDE[vsc_pkg::SEL_W-1:0];
            rx_term_q    <= vsc_pkg::RST_RXTERM[vsc_pkg::BIT_RXTERM];
            pulse_mask_q <= {vsc_pkg::RST_PULS, vsc_pkg::RST_PULS};
            eq_bits_q    <= {vsc_pkg::RST_EQ, vsc_pkg::RST_EQ};
            tx_set_q     <= vsc_pkg::RST_TX[vsc_pkg::TX_W-1:0];
        end else if (wr_en) begin
            case (ptr_q)
                vsc_pkg::ADDR_FAST: begin
                    fast_en_q  <= rx_shift_q[vsc_pkg::BIT_EN];
                    fast_sel_q <= rx_shift_q[vsc_pkg::SEL_W-1:0];
                end
                vsc_pkg::ADDR_SIDE: begin
                    side_en_q  <= rx_shift_q[vsc_pkg::BIT_EN];
                    side_sel_q <= rx_shift_q[vsc_pkg::SEL_W-1:0];
                end
                vsc_pkg::ADDR_RXTERM:  rx_term_q <= rx_shift_q[vsc_pkg::BIT_RXTERM];
                vsc_pkg::ADDR_PULS_AB: pulse_mask_q[7:0]  <= rx_shift_q;
                vsc_pkg::ADDR_PULS_CD: pulse_mask_q[15:8] <= rx_shift_q;
                vsc_pkg::ADDR_EQ_AB:   eq_bits_q[7:0]     <= rx_shift_q;
                vsc_pkg::ADDR_EQ_CD:   eq_bits_q[15:8]    <= rx_shift_q;
                vsc_pkg::ADDR_TX:      tx_set_q <= rx_shift_q[vsc_pkg::TX_W-1:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // termination pulse on every fast source change
    logic [1:0]                      prev_sel_q;
    logic [vsc_pkg::PULSE_CNT_W-1:0] pulse_cnt_q;
    logic [15:0]                     term_q;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            prev_sel_q  <= vsc_pkg::RST_FAST[vsc_pkg::SEL_W-1:0];
            pulse_cnt_q <= '0;
        end else begin
            prev_sel_q <= fast_sel_q;
            if (prev_sel_q != fast_sel_q) begin
                pulse_cnt_q <= vsc_pkg::PULSE_CNT_W'(TERM_PULSE_CYCLES);
            end else if (pulse_cnt_q != '0) begin
                pulse_cnt_q <= pulse_cnt_q - 1'b1;
            end
        end
    end
    // masked channels open while the window runs
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            term_q <= {vsc_pkg::CH_W{vsc_pkg::RST_RXTERM[vsc_pkg::BIT_RXTERM]}};
        end else begin
            term_q <= {vsc_pkg::CH_W{rx_term_q}}
                      & ~(pulse_mask_q & {vsc_pkg::CH_W{pulse_cnt_q != '0}});
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign o_sda                      = 1'b0;
    assign o_sda_oe                   = sda_oe_q;
    assign o_fast_path_enable         = fast_en_q;
    assign o_standby                  = ~fast_en_q;
    assign o_fast_source_select       = fast_sel_q;
    assign o_side_path_enable         = side_en_q;
    assign o_side_source_select       = side_sel_q;
    assign o_input_termination_on     = term_q;
    assign o_equalizer_level_bits     = eq_bits_q;
    assign o_output_preemphasis_level = tx_set_q[3:2];
    assign o_output_termination_on    = tx_set_q[1];
    assign o_output_current_level     = tx_set_q[0];
    assign o_parallel_path_off        = serial_used_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_reset_defaults: assert property (@(posedge i_clk) i_rst |=>
        fast_en_q && fast_sel_q == 2'h0 && tx_set_q == 4'h3 && !serial_used_q
        && pulse_mask_q == 16'h0000 && eq_bits_q == 16'h0000)
        else $error("defaults not restored by reset");
    a_flag_sticky: assert property (@(posedge i_clk) disable iff (i_rst)
        serial_used_q |=> serial_used_q)
        else $error("parallel disable flag dropped without reset");
    a_flag_on_match: assert property (@(posedge i_clk) disable iff (i_rst)
        byte_done && state_q == vsc_pkg::ST_DEV && dev_match |=> serial_used_q && sda_oe_q)
        else $error("matched address not acknowledged");
    a_addr_mismatch: assert property (@(posedge i_clk) disable iff (i_rst)
        byte_done && state_q == vsc_pkg::ST_DEV && !dev_match
        |=> state_q == vsc_pkg::ST_IDLE && !sda_oe_q)
        else $error("foreign address acknowledged");
    a_tx_write: assert property (@(posedge i_clk) disable iff (i_rst)
        wr_en && ptr_q == vsc_pkg::ADDR_TX |=> tx_set_q == $past(rx_shift_q[3:0]))
        else $error("transmitter settings write lost");
    a_fast_write: assert property (@(posedge i_clk) disable iff (i_rst)
        wr_en && ptr_q == vsc_pkg::ADDR_FAST
        |=> o_standby == !$past(rx_shift_q[6]) && rd_data[5:2] == 4'h0)
        else $error("fast path write or standby wrong");
    a_term_pulse: assert property (@(posedge i_clk) disable iff (i_rst)
        $changed(fast_sel_q) && rx_term_q && pulse_mask_q[0] |-> ##2 !term_q[0])
        else $error("masked channel kept termination on switch");
    a_term_off: assert property (@(posedge i_clk) disable iff (i_rst)
        !rx_term_q |=> term_q == 16'h0000)
        else $error("termination on while switched off");
    a_term_unmasked: assert property (@(posedge i_clk) disable iff (i_rst)
        rx_term_q |=> (term_q | $past(pulse_mask_q)) == 16'hffff)
        else $error("unmasked channel lost termination");
    a_idle_release: assert property (@(posedge i_clk) disable iff (i_rst)
        state_q == vsc_pkg::ST_IDLE |-> !sda_oe_q)
        else $error("data line driven while idle");

endmodule // vsc_config_regs

// [dv/vsc_i2c_master.sv]
`timescale 1ns/100ps
module vsc_i2c_master (
    // clock and wire level
    input  wire logic i_clk,
    input  wire logic i_sda_line,
    // master drives
    output logic      o_scl,
    output logic      o_sda_low
);
    // 10 clocks a phase, clear of the 8-clock minimum
    localparam int PH = 10;

    initial begin
        o_scl     = 1'b1;
        o_sda_low = 1'b0;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge i_clk);
        #10;
    endtask

    // data held past the fall so filtered edges never cross
    task automatic bit_io(input logic b, output logic r);
        o_sda_low = ~b;
        hold(PH);
        o_scl = 1'b1;
        hold(PH);
        r = i_sda_line;
        o_scl = 1'b0;
        hold(4);
    endtask

    task automatic start();
        o_sda_low = 1'b0;
        hold(PH);
        o_scl = 1'b1;
        hold(PH);
        o_sda_low = 1'b1;
        hold(PH);
        o_scl = 1'b0;
        hold(PH);
    endtask

    task automatic stop();
        o_sda_low = 1'b1;
        hold(PH);
        o_scl = 1'b1;
        hold(PH);
        o_sda_low = 1'b0;
        hold(PH);
    endtask

    task automatic send(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    // a nack closes every read
    task automatic recv(output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(1'b1, r);
    endtask
endmodule // vsc_i2c_master

// [dv/testbench.sv]
`timescale 1ns/100ps
module testbench;
    // short pulse so the run stays brief
    localparam int PULSE = 400;
    localparam logic [7:0] OFFS [8] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h20};
    localparam logic [7:0] DEFS [8] = '{8'h40, 8'h40, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03};
    logic        clk;
    logic        rst;
    logic [2:0]  pins;
    logic        scl;
    logic        m_low;
    logic        sda_out;
    logic        sda_oe;
    logic        fast_en;
    logic        standby;
    logic [1:0]  fast_sel;
    logic        side_en;
    logic [1:0]  side_sel;
    logic [15:0] term_on;
    logic [15:0] eq_bits;
    logic [1:0]  pre;
    logic        oterm;
    logic        ocur;
    logic        ppo;
    int          errors;
    int          checks_done;
    int          low_cnt = 0;
    // open drain, pulled up
    wire logic   sda_line = !(m_low || (sda_oe && !sda_out));

    vsc_config_regs #(.TERM_PULSE_CYCLES(PULSE)) vsc_config_regs_inst (
        .i_clk(clk), .i_rst(rst), .i_scl(scl), .i_sda(sda_line),
        .o_sda(sda_out), .o_sda_oe(sda_oe), .i_slave_id_pin_2(pins[2]),
        .i_slave_id_pin_1(pins[1]), .i_slave_id_pin_0(pins[0]),
        .o_fast_path_enable(fast_en), .o_standby(standby), .o_fast_source_select(fast_sel),
        .o_side_path_enable(side_en), .o_side_source_select(side_sel),
        .o_input_termination_on(term_on), .o_equalizer_level_bits(eq_bits),
        .o_output_preemphasis_level(pre), .o_output_termination_on(oterm),
        .o_output_current_level(ocur), .o_parallel_path_off(ppo));

    vsc_i2c_master vsc_i2c_master_inst (
        .i_clk(clk), .i_sda_line(sda_line), .o_scl(scl), .o_sda_low(m_low));

    always #50 clk = ~clk;
    always @(posedge clk) if (term_on !== 16'hffff) low_cnt <= low_cnt + 1;

    ////////////////////////////////////////////////////////////////////////////
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        if (errors == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic wr(input logic [7:0] ra, input logic [7:0] d);
        logic [2:0] a;
        vsc_i2c_master_inst.start();
        vsc_i2c_master_inst.send({4'h9, pins, 1'b0}, a[2]);
        vsc_i2c_master_inst.send(ra, a[1]);
        vsc_i2c_master_inst.send(d, a[0]);
        vsc_i2c_master_inst.stop();
        chk({13'h0, a}, 16'h0007);
    endtask

    task automatic rd(input logic [7:0] ra, output logic [7:0] d);
        logic [2:0] a;
        vsc_i2c_master_inst.start();
        vsc_i2c_master_inst.send({4'h9, pins, 1'b0}, a[2]);
        vsc_i2c_master_inst.send(ra, a[1]);
        vsc_i2c_master_inst.start();
        vsc_i2c_master_inst.send({4'h9, pins, 1'b1}, a[0]);
        vsc_i2c_master_inst.recv(d);
        vsc_i2c_master_inst.stop();
        chk({13'h0, a}, 16'h0007);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // straps at 101, so an address ending 100 belongs to someone else
    task automatic t_bad_addr();
        logic a;
        vsc_i2c_master_inst.start();
        vsc_i2c_master_inst.send({4'h9, 3'b100, 1'b0}, a);
        vsc_i2c_master_inst.stop();
        chk({15'h0, a}, 16'h0);
        chk({15'h0, ppo}, 16'h0);
        pins = 3'b100;
        hold(8);
    endtask

    task automatic t_defaults();
        logic [7:0] d;
        for (int i = 0; i < 8; i++) begin
            rd(OFFS[i], d);
            chk({8'h0, d}, {8'h0, DEFS[i]});
        end
        chk({15'h0, ppo}, 16'h1);
    endtask

    task automatic t_fields();
        logic [7:0] d;
        logic [1:0] s;
        wr(8'h00, 8'h7f);
        rd(8'h00, d);
        chk({8'h0, d}, 16'h0043);
        wr(8'h01, 8'h3f);
        rd(8'h01, d);
        chk({8'h0, d}, 16'h0003);
        for (int i = 0; i < 4; i++) begin
            s = i[1:0];
            wr(8'h00, {1'b0, s[0], 4'h0, s});
            chk({12'h0, fast_en, standby, fast_sel}, {12'h0, s[0], ~s[0], s});
            wr(8'h01, {1'b0, ~s[0], 4'h0, s});
            chk({13'h0, side_en, side_sel}, {13'h0, ~s[0], s});
            wr(8'h20, {4'h0, s, ~s[0], s[1]});
            chk({12'h0, pre, oterm, ocur}, {12'h0, s, ~s[0], s[1]});
        end
        wr(8'h13, 8'ha5);
        wr(8'h14, 8'h3c);
        chk(eq_bits, 16'h3ca5);
        rd(8'h14, d);
        chk({8'h0, d}, 16'h003c);
    endtask

    // unmapped writes vanish and read as zero
    task automatic t_unmapped();
        logic [7:0] d;
        wr(8'h15, 8'hff);
        rd(8'h15, d);
        chk({8'h0, d}, 16'h0000);
        rd(8'h20, d);
        chk({8'h0, d}, 16'h000d);
    endtask

    task automatic t_pulse();
        int n;
        int base;
        wr(8'h11, 8'h0f);
        wr(8'h12, 8'h80);
        // count from a snapshot; the counter has a single writer
        base = low_cnt;
        wr(8'h00, 8'h40);
        chk(term_on, 16'h7ff0);
        for (n = 0; n < 1000 && term_on !== 16'hffff; n++) hold(1);
        chk(term_on, 16'hffff);
        chk(16'(low_cnt - base), PULSE[15:0]);
        wr(8'h00, 8'h40);
        chk(16'(low_cnt - base), PULSE[15:0]);
        wr(8'h10, 8'h00);
        chk(term_on, 16'h0000);
        wr(8'h10, 8'h01);
        chk(term_on, 16'hffff);
    endtask

    task automatic t_reset();
        logic [7:0] d;
        rst = 1'b1;
        hold(2);
        rst = 1'b0;
        hold(6);
        chk({8'h0, ppo, fast_en, standby, fast_sel, side_en, side_sel}, 16'h0044);
        chk(term_on ^ eq_bits, 16'hffff);
        chk({12'h0, pre, oterm, ocur}, 16'h0003);
        rd(8'h13, d);
        chk({8'h0, d}, 16'h0000);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        pins = 3'b101;
        errors = 0;
        checks_done = 0;
        hold(8);
        rst = 1'b0;
        hold(6);
        t_bad_addr();
        t_defaults();
        t_fields();
        t_unmapped();
        t_pulse();
        t_reset();
        wrap_up();
    end

    // hang guard
    initial begin
        repeat (100000) @(posedge clk);
        errors++;
        wrap_up();
    end
endmodule // testbench
